// ---- src/timer_front_pkg.sv ----
// package: register map, field layout and reset values of the timer unit front end
package timer_front_pkg;
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0]  off_peripheral_clock_enable = 8'h00;
   localparam logic [7:0]  off_timer_prescale_select   = 8'h04;
   localparam logic [7:0]  off_timer_channel_stop      = 8'h08;
   localparam logic [7:0]  off_channel_enable_status   = 8'h0c;
   localparam logic [7:0]  off_channel_start           = 8'h10;
   // ------------------------------------------------------------
   // field layout
   // ------------------------------------------------------------
   localparam int          timer_unit_clock_gate_bit   = 0;
   localparam logic [15:0] prescale_select_mask        = 16'h33ff;
   localparam logic [15:0] channel_stop_mask           = 16'h0aff;
   localparam int          clk0_lsb                    = 0;
   localparam int          clk1_lsb                    = 4;
   localparam int          clk2_lsb                    = 8;
   localparam int          clk3_lsb                    = 12;
   localparam int          num_channels                = 8;
   localparam int          upper1_bit                  = 9;
   localparam int          upper3_bit                  = 11;
   localparam int          prescale_width              = 15;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0]  peripheral_enable_reset     = 8'h00;
   localparam logic [15:0] prescale_select_reset       = 16'h0000;
   localparam logic [9:0]  status_reset                = 10'h000;
   // ------------------------------------------------------------
   // bus encodings
   // ------------------------------------------------------------
   localparam logic [1:0]  htrans_nonseq               = 2'h2;
   localparam logic [1:0]  htrans_seq                  = 2'h3;
   localparam logic [2:0]  hsize_word                  = 3'h2;
endpackage : timer_front_pkg

// ---- src/clock_prescaler.sv ----
// one power-of-two prescaler: single-cycle tick at fclk / 2^code
`timescale 1ns/1ps
module clock_prescaler (
   input  wire logic                                       hclk,
   input  wire logic                                       hresetn,
   input  wire logic [timer_front_pkg::prescale_width-1:0] count,
   input  wire logic [3:0]                                 code,
   output logic                                            tick
);
   typedef struct packed {
      logic tick;
   } state_t;
   state_t st;
   state_t next_st;
   logic [timer_front_pkg::prescale_width:0] mask;

   always_comb begin
      next_st = st;
      mask = (16'h0001 << code) - 16'h0001;
      // tick when all bits below the selected tap are ones; code 0 ticks every cycle
      next_st.tick = ({1'b0, count} & mask) == mask;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign tick = st.tick;
endmodule : clock_prescaler

// ---- src/timer_unit_front.sv ----
// timer unit front end: clock gate, four operation clock prescalers, channel stop triggers
// Operation
// - enable bit 0 clear withholds the unit clock; set supplies it
// - operation clock zero equals fclk divided by two to the code
// - prescale select holds fields 3-0, 7-4, 9-8, 13-12; others read zero
// - writing one to a stop bit generates that channel's stop trigger
// - a stopped channel has its enable status bit cleared
// - stop bits for channels 0-7 in bits 7-0, upper halves at 9, 11
//
// Our own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module timer_unit_front (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             unit_clock_enable,
   output logic [3:0]       operation_clock_tick,
   output logic [9:0]       channel_stop_trigger,
   output logic [9:0]       channel_enable_status
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic        wr_pending;
      logic [7:0]  wr_addr;
      logic [31:0] rdata;
      logic [7:0]  peripheral_clock_enable;
      logic [15:0] timer_prescale_select;
      logic [9:0]  stop_pulse;
      logic [9:0]  status;
      logic [14:0] count;
      logic        gate;
      logic [3:0]  ticks;
   } state_t;

   // eight channels plus the upper halves of channels one and three
   localparam int num_slots = timer_front_pkg::num_channels + 2;

   localparam state_t state_reset = '{
      wr_pending:              1'b0,
      wr_addr:                 8'h00,
      rdata:                   32'h0000_0000,
      peripheral_clock_enable: timer_front_pkg::peripheral_enable_reset,
      timer_prescale_select:   timer_front_pkg::prescale_select_reset,
      stop_pulse:              10'h000,
      status:                  timer_front_pkg::status_reset,
      count:                   15'h0000,
      gate:                    1'b0,
      ticks:                   4'h0
   };

   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   state_t      st;
   state_t      next_st;
   logic [3:0]  tick;
   logic [3:0]  codes [4];
   logic [15:0] stop_word;
   logic [9:0]  start_bits;
   logic [9:0]  stop_bits;
   logic [9:0]  status_bits;
   logic        accept;
   logic        wr_enable_hit;
   logic        wr_select_hit;
   logic        wr_stop_hit;
   logic        wr_start_hit;
   logic [31:0] read_word;

   // ------------------------------------------------------------
   // bus address phase
   // ------------------------------------------------------------
   // hready low means another slave stalls the bus, so nothing is taken then
   assign accept = hsel && hready &&
                   (htrans == timer_front_pkg::htrans_nonseq || htrans == timer_front_pkg::htrans_seq);

   // ------------------------------------------------------------
   // write decode, one data phase after the address
   // ------------------------------------------------------------
   // offsets that match no register fall through, so those writes vanish
   assign wr_enable_hit = st.wr_pending && st.wr_addr == timer_front_pkg::off_peripheral_clock_enable;
   assign wr_select_hit = st.wr_pending && st.wr_addr == timer_front_pkg::off_timer_prescale_select;
   assign wr_stop_hit   = st.wr_pending && st.wr_addr == timer_front_pkg::off_timer_channel_stop;
   assign wr_start_hit  = st.wr_pending && st.wr_addr == timer_front_pkg::off_channel_start;

   // ------------------------------------------------------------
   // read mux, sampled in the address phase and held for the data phase
   // ------------------------------------------------------------
   always_comb begin
      read_word = 32'h0000_0000;
      unique case (haddr[7:0])
         timer_front_pkg::off_peripheral_clock_enable: begin
            read_word = {24'h00_0000, st.peripheral_clock_enable};
         end
         timer_front_pkg::off_timer_prescale_select: begin
            read_word = {16'h0000, st.timer_prescale_select};
         end
         timer_front_pkg::off_channel_enable_status: begin
            read_word = {22'h00_0000, st.status};
         end
         // the stop and start registers are write-only pulses
         default: begin
            read_word = 32'h0000_0000;
         end
      endcase
   end

   // ------------------------------------------------------------
   // channel slots: channels 0-7, then the upper halves of 1 and 3
   // ------------------------------------------------------------
   assign stop_word = hwdata[15:0] & timer_front_pkg::channel_stop_mask;

   genvar s;
   generate
      for (s = 0; s < num_slots; s++) begin : gen_slot
         localparam int pos = (s < timer_front_pkg::num_channels) ? s :
                              (s == timer_front_pkg::num_channels) ? timer_front_pkg::upper1_bit :
                              timer_front_pkg::upper3_bit;
         assign stop_bits[s]   = stop_word[pos];
         assign start_bits[s]  = hwdata[pos];
         // stop and start sit in separate registers, so they never land together
         assign status_bits[s] = (wr_stop_hit && stop_bits[s]) ? 1'b0 :
                                 (wr_start_hit && start_bits[s]) ? 1'b1 :
                                 st.status[s];
      end
   endgenerate

   // ------------------------------------------------------------
   // prescalers, one per operation clock
   // ------------------------------------------------------------
   // clocks two and three have two-bit fields, so they reach fclk / 8 at most
   always_comb begin
      codes[0] = st.timer_prescale_select[timer_front_pkg::clk0_lsb +: 4];
      codes[1] = st.timer_prescale_select[timer_front_pkg::clk1_lsb +: 4];
      codes[2] = {2'h0, st.timer_prescale_select[timer_front_pkg::clk2_lsb +: 2]};
      codes[3] = {2'h0, st.timer_prescale_select[timer_front_pkg::clk3_lsb +: 2]};
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gen_prescale
         // all four share one counter, so their ticks stay in phase
         clock_prescaler u_prescale (
            .hclk    (hclk),
            .hresetn (hresetn),
            .count   (st.count),
            .code    (codes[g]),
            .tick    (tick[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.wr_pending = 1'b0;
      next_st.rdata = 32'h0000_0000;
      next_st.stop_pulse = 10'h000;

      // the unit clock follows the enable bit one cycle later
      next_st.gate = st.peripheral_clock_enable[timer_front_pkg::timer_unit_clock_gate_bit];
      // the prescaler counter only runs while the unit clock is supplied
      next_st.count = st.gate ? st.count + 15'h0001 : 15'h0000;
      // a tick leaves only while the gate is open and stays open, so none slips past a closing gate
      next_st.ticks = (next_st.gate && st.gate) ? tick : 4'h0;

      // data phase of a write
      if (wr_enable_hit) begin
         next_st.peripheral_clock_enable = hwdata[7:0];
      end
      if (wr_select_hit) begin
         next_st.timer_prescale_select = hwdata[15:0] & timer_front_pkg::prescale_select_mask;
      end
      if (wr_stop_hit) begin
         // ones fire a pulse, zeros leave the channel alone
         next_st.stop_pulse = stop_bits;
      end
      // start sets and stop clears, slot by slot
      next_st.status = status_bits;

      // address phase
      if (accept) begin
         next_st.wr_pending = hwrite;
         next_st.wr_addr = haddr[7:0];
         if (!hwrite) begin
            next_st.rdata = read_word;
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= state_reset;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // the block never stalls and never errors, so the response is tied
   assign hrdata = st.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign unit_clock_enable = st.gate;
   assign operation_clock_tick = st.ticks;
   assign channel_stop_trigger = st.stop_pulse;
   assign channel_enable_status = st.status;
endmodule : timer_unit_front

// ---- sim/timer_unit_front_props.sv ----
// checker: port-level properties of the timer unit front end
`timescale 1ns/1ps
module timer_unit_front_props (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        unit_clock_enable,
   input wire logic [3:0]  operation_clock_tick,
   input wire logic [9:0]  channel_stop_trigger,
   input wire logic [9:0]  channel_enable_status
);
   logic       wr_q;
   logic       rd_q;
   logic [7:0] addr_q;
   logic [9:0] want_q;
   logic [3:0] code0_q;
   // data phase tracking, so each property sees the transfer it belongs to
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q    <= 1'b0;
         rd_q    <= 1'b0;
         addr_q  <= 8'h00;
         want_q  <= 10'h000;
         code0_q <= 4'h0;
      end else begin
         wr_q    <= hsel && hready && htrans[1] && hwrite;
         rd_q    <= hsel && hready && htrans[1] && !hwrite;
         addr_q  <= haddr[7:0];
         want_q  <= {hwdata[11], hwdata[9], hwdata[7:0]};
         code0_q <= (wr_q && addr_q == 8'h04) ? hwdata[3:0] : code0_q;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   property p_gate; !unit_clock_enable |-> operation_clock_tick == 4'h0; endproperty
   a_gate: assert property (p_gate) else $error("tick while gated off");
   // code held three cycles, so the two-cycle tick lag cannot mislead
   property p_div;
      operation_clock_tick[0] && code0_q != 4'h0 && code0_q == $past(code0_q) && code0_q == $past(code0_q, 2)
         |=> !operation_clock_tick[0];
   endproperty
   a_div: assert property (p_div) else $error("clock zero ticks too often");
   property p_rsvd; rd_q && addr_q == 8'h04 |-> (hrdata & ~32'h000033ff) == 32'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved select bits set");
   property p_trig; wr_q && addr_q == 8'h08 |=> channel_stop_trigger == want_q; endproperty
   a_trig: assert property (p_trig) else $error("stop pulse mismatch");
   property p_clr;
      channel_stop_trigger != 10'h000 |-> (channel_stop_trigger & channel_enable_status) == 10'h000;
   endproperty
   a_clr: assert property (p_clr) else $error("stopped channel still enabled");
   property p_idle; !(wr_q && addr_q == 8'h08) |=> channel_stop_trigger == 10'h000; endproperty
   a_idle: assert property (p_idle) else $error("stop pulse without write");
   property p_rd0; rd_q && addr_q == 8'h08 |-> hrdata == 32'h0; endproperty
   a_rd0: assert property (p_rd0) else $error("stop register reads nonzero");
endmodule : timer_unit_front_props
bind timer_unit_front timer_unit_front_props i_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hready, .hrdata, .unit_clock_enable, .operation_clock_tick, .channel_stop_trigger, .channel_enable_status);

// ---- sim/timer_unit_front_bench.sv ----
// bench: directed tests of the timer unit front end over its bus
`timescale 1ns/1ps
module timer_unit_front_bench;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rd_s;
   logic        hreadyout;
   logic        gate;
   logic [3:0]  tick;
   logic [9:0]  trig;
   logic [9:0]  stat;
   int          bad_count = 0;
   int          n_compared = 0;
   int          cycles = 0;
   always #2 hclk = ~hclk;
   // read data captured mid data phase, so the closing edge cannot race it
   always @(negedge hclk) rd_s <= hrdata;
   timer_unit_front i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(timer_front_pkg::hsize_word),
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .unit_clock_enable(gate),
      .operation_clock_tick(tick), .channel_stop_trigger(trig), .channel_enable_status(stat));
   task stop_test;
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         stop_test();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= timer_front_pkg::htrans_nonseq;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = rd_s;
   endtask : bus
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r, exp);
   endtask : rd
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_regs;
      wr(8'h20, 32'hffffffff);
      rd(8'h00, 32'h0);
      chk({31'h0, gate}, 32'h0);
      wr(8'h04, 32'hffffffff);
      rd(8'h04, 32'h000033ff);
      rd(8'h08, 32'h0);
      $display("register test done");
   endtask : t_regs
   task t_tick;
      int          n [4];
      logic [31:0] w;
      for (int c = 0; c < 5; c++) begin
         // clock one counts the other way; clocks two and three take the low two bits
         w = {18'h0, 2'(c), 2'h0, 2'(c), 4'(4 - c), 4'(c)};
         wr(8'h04, w);
         wr(8'h00, 32'h1);
         repeat (8) @(negedge hclk);
         chk({31'h0, gate}, 32'h1);
         n = '{0, 0, 0, 0};
         repeat (128) begin
            @(negedge hclk);
            for (int k = 0; k < 4; k++) n[k] += (tick[k] === 1'b1);
         end
         chk(n[0], 128 >> c);
         chk(n[1], 128 >> (4 - c));
         chk(n[2], 128 >> (c % 4));
         chk(n[3], 128 >> (c % 4));
      end
      wr(8'h00, 32'h0);
      repeat (4) @(negedge hclk);
      chk({31'h0, gate}, 32'h0);
      // clock one is left at code zero, so any leak through the closed gate shows
      n[0] = 0;
      repeat (16) begin
         @(negedge hclk);
         n[0] += (tick !== 4'h0);
      end
      chk(n[0], 0);
      $display("tick test done");
   endtask : t_tick
   task t_stop;
      wr(8'h10, 32'h00000aff);
      rd(8'h0c, 32'h000003ff);
      wr(8'h08, 32'h00000a05);
      wr(8'h08, 32'h0);
      rd(8'h0c, 32'h000000fa);
      wr(8'h08, 32'h0000f5ff);
      rd(8'h0c, 32'h0);
      $display("stop test done");
   endtask : t_stop
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_tick();
      t_stop();
      stop_test();
   end
endmodule : timer_unit_front_bench
